// ---- hw/fskph_top.v ----
// fskph_top.v: fsk packet framer, 64-byte fifo, tx and rx byte engines
// assumes byte-wide modem strobes on i_clock; host fifo strobes are synchronous
`timescale 1ns/1ns
`include "fskph_defines.vh"
module fskph_top #(
	parameter DEPTH = `FSKPH_FIFO_DEPTH,
	parameter AW = 6
) (
	input wire i_clock, // core clock
	input wire i_rst, // synchronous reset, high
	input wire i_tx_mode, // chip in transmit
	input wire i_rx_mode, // chip in receive
	input wire i_frame_format_sel, // 1 variable length
	input wire [10:0] i_payload_len_limit, // length / limit
	input wire i_send_start_cond, // 1 start at first byte
	input wire [5:0] i_queue_level_setting, // fifo threshold
	input wire i_sync_enable, // sync word used
	input wire [1:0] i_sync_size, // sync bytes minus one
	input wire [31:0] i_sync_pattern, // sync bytes, first in msb
	input wire [7:0] i_preamble_len, // preamble bytes
	input wire i_crc_enable, // crc on
	input wire i_crc_fail_keep, // keep payload on crc fail
	input wire i_crc_type_sel, // 0 ccitt 1 ibm
	input wire [1:0] i_dc_free_sel, // 01 manchester 10 whitening
	input wire [1:0] i_addr_filter_sel, // address filter
	input wire [7:0] i_node_identifier, // node address
	input wire [7:0] i_bcast_identifier, // broadcast address
	input wire i_fifo_wr, // host write strobe
	input wire [7:0] i_fifo_wdata, // host write byte
	input wire i_fifo_rd, // host read strobe
	output reg [7:0] o_fifo_rdata, // byte read
	output wire o_queue_level_flag, // above threshold
	output wire o_queue_drained_flag, // fifo empty
	output wire o_queue_full_flag, // fifo full
	output reg [7:0] o_mod_byte, // byte to modulator
	output reg o_mod_valid, // byte strobe to modulator
	output reg o_mod_manch, // modulator should manchester this byte
	input wire i_mod_ready, // modulator takes byte
	input wire i_mod_idle, // modulator has sent last bit
	input wire i_dem_valid, // demod byte strobe
	input wire [7:0] i_dem_byte, // demod byte, already manchester decoded
	output reg o_dem_manch, // demod should manchester decode
	output reg o_frame_sent_flag, // packet sent
	output reg o_payload_avail_flag, // payload ready, event pin 0
	output reg o_crc_pass_flag, // crc ok
	output reg o_sync_addr_hit // sync / address match
);
	// fifo storage
	reg [7:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wp_q, rp_q;
	reg [AW:0] cnt_q;
	reg [10:0] wr_total_q;
	wire full = (cnt_q == DEPTH);
	wire empty = (cnt_q == 0);
	assign o_queue_full_flag = full;
	assign o_queue_drained_flag = empty;
	assign o_queue_level_flag = (cnt_q > {1'b0, i_queue_level_setting});
	wire unlim = !i_frame_format_sel && (i_payload_len_limit == 11'h000);
	wire varlen = i_frame_format_sel;
	wire fixed = !i_frame_format_sel && !unlim;

	// crc step over one byte, msb first
	function [15:0] fskph_crc;
		input [15:0] c;
		input [7:0] b;
		input sel;
		integer k;
		reg [15:0] r;
		begin
			r = c;
			for (k = 7; k >= 0; k = k - 1) begin
				if (r[15] ^ b[k])
					r = {r[14:0], 1'b0} ^ (sel ? `FSKPH_IBM_POLY : `FSKPH_CCITT_POLY);
				else
					r = {r[14:0], 1'b0};
			end
			fskph_crc = r;
		end
	endfunction
	// whitening lfsr advance by eight bits, x9+x5+1
	function [8:0] fskph_lfsr;
		input [8:0] s;
		integer k;
		reg [8:0] r;
		begin
			r = s;
			for (k = 0; k < 8; k = k + 1)
				r = {r[0] ^ r[5], r[8:1]};
			fskph_lfsr = r;
		end
	endfunction
	function [15:0] fskph_seed;
		input sel;
		begin
			fskph_seed = sel ? `FSKPH_IBM_SEED : `FSKPH_CCITT_SEED;
		end
	endfunction

	// engine states
	localparam S_IDLE = 7'h01, S_PRE = 7'h02, S_SYNC = 7'h04, S_DATA = 7'h08;
	localparam S_CRC = 7'h10, S_DONE = 7'h20, S_RXD = 7'h40;
	reg [6:0] st_q;
	reg [10:0] bcnt_q, rlen_q;
	reg [7:0] pcnt_q;
	reg [1:0] scnt_q, ccnt_q;
	reg [15:0] crc_q;
	reg [8:0] wh_q;
	reg [31:0] sh_q;
	reg started_q;
	wire white = (i_dc_free_sel == `FSKPH_DC_WHITE);
	wire manch = (i_dc_free_sel == `FSKPH_DC_MAN);
	wire rx_dc_ok = i_sync_enable || !unlim;
	wire [15:0] crc_out = i_crc_type_sel ? crc_q : ~crc_q;
	wire start_ok = i_send_start_cond ? (wr_total_q != 11'h000)
		: (wr_total_q >= {5'h00, i_queue_level_setting} + 11'h001);
	// sync search looks at the trailing size+1 received bytes, newest in the low byte
	wire [5:0] sync_bits = {1'b0, i_sync_size, 3'h0} + 6'h08;
	wire [31:0] sync_mask = ~(32'hFFFFFFFF << sync_bits);
	wire [31:0] sync_ref = i_sync_pattern >> (6'h20 - sync_bits);
	wire tx_take = (st_q == S_DATA) && i_mod_ready && !empty;
	wire [7:0] rx_b = (white && rx_dc_ok) ? (i_dem_byte ^ wh_q[7:0]) : i_dem_byte;
	reg rx_push, rx_clear;
	// rx byte pushed into fifo
	wire do_push = rx_push && !full;
	wire do_pop = (i_fifo_rd && !empty) || tx_take;

	// fifo pointers and storage; host writes and rx pushes share the write port
	always @(posedge i_clock) begin
		if (i_rst || rx_clear) begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if ((i_fifo_wr && !full && !i_rx_mode) || do_push) begin
				mem_q[wp_q] <= do_push ? rx_b : i_fifo_wdata;
				wp_q <= wp_q + 1'b1;
			end
			if (do_pop)
				rp_q <= rp_q + 1'b1;
			cnt_q <= cnt_q + {{AW{1'b0}}, ((i_fifo_wr && !full && !i_rx_mode) || do_push)}
				- {{AW{1'b0}}, do_pop};
		end
	end
	// host read data and written-byte count, kept across sleep for start
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_fifo_rdata <= 8'h00;
			wr_total_q <= 11'h000;
		end else begin
			if (i_fifo_rd && !empty)
				o_fifo_rdata <= mem_q[rp_q];
			if (st_q == S_DONE)
				wr_total_q <= 11'h000;
			else if (i_fifo_wr && !full && !i_rx_mode && wr_total_q != 11'h7FF)
				wr_total_q <= wr_total_q + 11'h001;
		end
	end

	// rx combinational decisions
	reg rx_drop, rx_last;
	// packet length in force, taking the length byte itself into account
	wire [10:0] rx_len = (varlen && bcnt_q == 11'h000) ? {3'h0, rx_b} + 11'h001 : rlen_q;
	always @* begin
		rx_push = 1'b0;
		rx_drop = 1'b0;
		rx_last = 1'b0;
		if (st_q == S_RXD && i_dem_valid) begin
			if (varlen && bcnt_q == 11'h000 && i_payload_len_limit != `FSKPH_LEN_NO_CHECK
				&& {3'h0, rx_b} > i_payload_len_limit)
				rx_drop = 1'b1;
			else if (rx_dc_ok && i_addr_filter_sel != 2'h0
				&& bcnt_q == (varlen ? 11'h001 : 11'h000)
				&& !(rx_b == i_node_identifier
				|| (i_addr_filter_sel == `FSKPH_AF_BOTH && rx_b == i_bcast_identifier)))
				rx_drop = 1'b1;
			else if (rlen_q != 11'h000 && bcnt_q >= rlen_q)
				rx_last = (ccnt_q == 2'h1); // crc byte phase
			else begin
				rx_push = 1'b1;
				// without crc the final payload byte ends the packet
				rx_last = !i_crc_enable && !unlim && (bcnt_q + 11'h001 >= rx_len);
			end
		end
	end
	wire rx_crc_bad = (crc_q != {sh_q[7:0], rx_b} && i_crc_enable); // stored crc vs received
	always @* begin
		rx_clear = 1'b0;
		if (st_q == S_RXD && i_dem_valid && rx_last && rx_crc_bad && !i_crc_fail_keep)
			rx_clear = 1'b1;
	end

	// main sequencer for both directions
	always @(posedge i_clock) begin
		if (i_rst) begin
			st_q <= S_IDLE;
			bcnt_q <= 11'h000;
			rlen_q <= 11'h000;
			pcnt_q <= 8'h00;
			scnt_q <= 2'h0;
			ccnt_q <= 2'h0;
			crc_q <= 16'h0000;
			wh_q <= `FSKPH_WHITE_SEED;
			sh_q <= 32'h00000000;
			started_q <= 1'b0;
			o_mod_byte <= 8'h00;
			o_mod_valid <= 1'b0;
			o_mod_manch <= 1'b0;
			o_dem_manch <= 1'b0;
			o_frame_sent_flag <= 1'b0;
			o_payload_avail_flag <= 1'b0;
			o_crc_pass_flag <= 1'b0;
			o_sync_addr_hit <= 1'b0;
		end else begin
			o_mod_valid <= 1'b0;
			o_dem_manch <= 1'b0;
			case (st_q)
			S_IDLE: begin
				crc_q <= fskph_seed(i_crc_type_sel);
				wh_q <= `FSKPH_WHITE_SEED;
				bcnt_q <= 11'h000;
				ccnt_q <= 2'h0;
				scnt_q <= 2'h0;
				if (i_tx_mode) begin
					o_frame_sent_flag <= 1'b0;
					pcnt_q <= 8'h00;
					st_q <= S_PRE;
				end else if (i_rx_mode) begin
					// flags stand until the next packet is found
					sh_q <= 32'h00000000;
					rlen_q <= i_payload_len_limit;
					st_q <= S_SYNC;
				end
			end
			S_PRE: begin
				if (!i_tx_mode)
					st_q <= S_IDLE;
				else if (i_mod_ready) begin
					o_mod_valid <= 1'b1;
					o_mod_manch <= 1'b0;
					// idle filler is preamble, or constant zero without preamble
					o_mod_byte <= (i_preamble_len == 8'h00) ? 8'h00 : `FSKPH_PREAMBLE_BYTE;
					if (pcnt_q != 8'hFF)
						pcnt_q <= pcnt_q + 8'h01;
					if (started_q || start_ok)
						started_q <= 1'b1;
					if ((started_q || start_ok) && pcnt_q + 8'h01 >= i_preamble_len) begin
						st_q <= i_sync_enable ? S_SYNC : S_DATA;
						rlen_q <= i_payload_len_limit;
					end
				end
			end
			S_SYNC: begin
				if (i_tx_mode) begin
					if (i_mod_ready) begin
						o_mod_valid <= 1'b1;
						o_mod_byte <= i_sync_pattern[31 - {scnt_q, 3'h0} -: 8];
						scnt_q <= scnt_q + 2'h1;
						if (scnt_q == i_sync_size)
							st_q <= S_DATA;
					end
				end else if (!i_rx_mode)
					st_q <= S_IDLE;
				else if (!i_sync_enable) begin
					o_payload_avail_flag <= 1'b0;
					o_crc_pass_flag <= 1'b0;
					st_q <= S_RXD;
				end else if (i_dem_valid) begin
					sh_q <= {sh_q[23:0], i_dem_byte};
					if (({sh_q[23:0], i_dem_byte} & sync_mask) == sync_ref) begin
						o_sync_addr_hit <= 1'b1;
						o_payload_avail_flag <= 1'b0;
						o_crc_pass_flag <= 1'b0;
						st_q <= S_RXD;
					end
				end
			end
			S_DATA: begin
				if (!i_tx_mode)
					st_q <= S_IDLE;
				else if (tx_take) begin
					o_mod_valid <= 1'b1;
					o_mod_manch <= manch;
					o_mod_byte <= white ? (mem_q[rp_q] ^ wh_q[7:0]) : mem_q[rp_q];
					wh_q <= fskph_lfsr(wh_q);
					crc_q <= fskph_crc(crc_q, mem_q[rp_q], i_crc_type_sel);
					bcnt_q <= bcnt_q + 11'h001;
					if (varlen && bcnt_q == 11'h000)
						rlen_q <= {3'h0, mem_q[rp_q]} + 11'h001;
					else if (!unlim && bcnt_q + 11'h001 >= rlen_q)
						st_q <= i_crc_enable ? S_CRC : S_DONE;
				end else if (unlim && empty && started_q && i_crc_enable)
					st_q <= S_CRC;
				else if (unlim && empty && started_q)
					st_q <= S_DONE;
			end
			S_CRC: begin
				if (i_mod_ready) begin
					o_mod_valid <= 1'b1;
					o_mod_manch <= manch;
					o_mod_byte <= (ccnt_q == 2'h0 ? crc_out[15:8] : crc_out[7:0])
						^ (white ? wh_q[7:0] : 8'h00);
					wh_q <= fskph_lfsr(wh_q);
					ccnt_q <= ccnt_q + 2'h1;
					if (ccnt_q == 2'h1)
						st_q <= S_DONE;
				end
			end
			S_DONE: begin
				started_q <= 1'b0;
				if (!i_rx_mode && i_mod_idle && !o_mod_valid) begin
					o_frame_sent_flag <= 1'b1;
					st_q <= S_IDLE;
				end
			end
			S_RXD: begin
				o_dem_manch <= manch && rx_dc_ok;
				if (!i_rx_mode)
					st_q <= S_IDLE;
				else if (rx_drop) begin
					o_sync_addr_hit <= 1'b0;
					st_q <= S_IDLE;
				end else if (i_dem_valid) begin
					bcnt_q <= bcnt_q + 11'h001;
					wh_q <= fskph_lfsr(wh_q);
					sh_q <= {sh_q[23:0], rx_b};
					if (rx_push) begin
						crc_q <= fskph_crc(crc_q, rx_b, i_crc_type_sel);
						if (varlen && bcnt_q == 11'h000)
							rlen_q <= {3'h0, rx_b} + 11'h001;
					end else begin
						ccnt_q <= ccnt_q + 2'h1;
						if (ccnt_q == 2'h0)
							crc_q <= crc_out;
					end
					if (rx_last && !unlim) begin
						o_crc_pass_flag <= i_crc_enable && !rx_crc_bad;
						o_payload_avail_flag <= !rx_crc_bad || i_crc_fail_keep;
						st_q <= S_DONE;
					end
				end
			end
			default: st_q <= S_IDLE;
			endcase
			if (st_q == S_DONE && i_rx_mode) // rx end needs no modulator drain
				st_q <= S_IDLE;
		end
	end
endmodule

// ---- hw/fskph_defines.vh ----
// fskph_defines.vh: constants for the fsk packet handler
// assumes inclusion by bare name from the design file
`ifndef FSKPH_DEFINES_VH
`define FSKPH_DEFINES_VH
`define FSKPH_FIFO_DEPTH 64
`define FSKPH_LEN_NO_CHECK 11'h7FF
`define FSKPH_CCITT_SEED 16'h1D0F
`define FSKPH_IBM_SEED 16'hFFFF
`define FSKPH_CCITT_POLY 16'h1021
`define FSKPH_IBM_POLY 16'h8005
`define FSKPH_WHITE_SEED 9'h1FF
`define FSKPH_AF_NODE 2'h1
`define FSKPH_AF_BOTH 2'h2
`define FSKPH_DC_MAN 2'h1
`define FSKPH_DC_WHITE 2'h2
`define FSKPH_PREAMBLE_BYTE 8'hAA
`endif

// ---- tb/fskph_top_assertions.sv ----
// fskph_top_assertions.sv: port checker for the packet framer
// assumes binding onto fskph_top with one clock domain
`timescale 1ns/1ns
module fskph_chk (
	input wire i_clock, // clock
	input wire i_rst, // reset
	input wire i_tx_mode, // tx mode
	input wire i_frame_format_sel, // format
	input wire [10:0] i_payload_len_limit, // limit
	input wire i_crc_enable, // crc on
	input wire i_crc_fail_keep, // keep
	input wire i_mod_ready, // ready
	input wire i_mod_idle, // idle
	input wire o_queue_level_flag, // level
	input wire o_queue_drained_flag, // empty
	input wire o_queue_full_flag, // full
	input wire o_mod_valid, // strobe
	input wire o_frame_sent_flag, // sent
	input wire o_payload_avail_flag, // avail
	input wire o_crc_pass_flag, // crc ok
	input wire o_sync_addr_hit // hit
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// modulator strobe shape and cause
	a_mod_quiet_sent: assert property (o_frame_sent_flag |-> !o_mod_valid)
		else $error("mod strobe while sent flag up");
	a_mod_needs_ready: assert property (o_mod_valid |-> $past(i_mod_ready) && $past(i_tx_mode))
		else $error("mod strobe without ready or tx");
	a_sent_after_idle: assert property ($rose(o_frame_sent_flag) |-> $past(i_mod_idle))
		else $error("sent before last bit");
	// queue flags
	a_full_not_empty: assert property (!(o_queue_full_flag && o_queue_drained_flag))
		else $error("full and empty");
	a_level_not_empty: assert property (o_queue_level_flag |-> !o_queue_drained_flag)
		else $error("level while empty");
	// receive flags
	a_unlim_no_flags: assert property (($rose(o_payload_avail_flag) || $rose(o_crc_pass_flag))
		|-> (i_frame_format_sel || i_payload_len_limit != 11'h000))
		else $error("flag in unlimited");
	a_crc_gates_avail: assert property ($rose(o_payload_avail_flag) && i_crc_enable
		&& !i_crc_fail_keep |-> o_crc_pass_flag)
		else $error("avail after crc fail");
	a_hit_before_avail: assert property ($rose(o_payload_avail_flag) |-> $past(o_sync_addr_hit))
		else $error("avail without sync");
endmodule
bind fskph_top fskph_chk u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_tx_mode(i_tx_mode),
	.i_frame_format_sel(i_frame_format_sel), .i_payload_len_limit(i_payload_len_limit),
	.i_crc_enable(i_crc_enable), .i_crc_fail_keep(i_crc_fail_keep), .i_mod_ready(i_mod_ready),
	.i_mod_idle(i_mod_idle), .o_queue_level_flag(o_queue_level_flag),
	.o_queue_drained_flag(o_queue_drained_flag), .o_queue_full_flag(o_queue_full_flag),
	.o_mod_valid(o_mod_valid), .o_frame_sent_flag(o_frame_sent_flag),
	.o_payload_avail_flag(o_payload_avail_flag), .o_crc_pass_flag(o_crc_pass_flag),
	.o_sync_addr_hit(o_sync_addr_hit));

// ---- tb/fskph_modem_model.sv ----
// fskph_modem_model.sv: byte modulator and demodulator stand-in
// assumes one byte per framer strobe, same clock as the framer
`timescale 1ns/1ns
module fskph_modem_model (
	input wire i_clock, // clock
	input wire i_mod_valid, // byte strobe
	input wire [7:0] i_mod_byte, // byte from framer
	output reg o_mod_ready = 1'b0, // takes bytes
	output reg o_mod_idle = 1'b1, // last bit gone
	output reg o_dem_valid = 1'b0, // rx strobe
	output reg [7:0] o_dem_byte = 8'h00 // rx byte
);
	reg slow = 1'b0; // paced ready when set
	reg [3:0] bits = 4'h0; // bits still on air
	reg [7:0] got[$]; // bytes seen on air
	// take bytes, idle only once the last bit has shifted out
	always @(posedge i_clock) begin
		o_mod_ready <= slow ? (bits == 4'h0) && !i_mod_valid && !o_mod_ready : 1'b1;
		if (i_mod_valid) begin
			got.push_back(i_mod_byte);
			bits <= 4'h8;
		end else if (bits != 4'h0)
			bits <= bits - 4'h1;
		o_mod_idle <= !i_mod_valid && bits <= 4'h1;
	end
	// one demodulated byte, line shows inverse once released; strobe gap between bytes
	task send(input [7:0] b);
		begin
			@(posedge i_clock);
			o_dem_valid <= 1'b1;
			o_dem_byte <= b;
			@(posedge i_clock);
			o_dem_valid <= 1'b0;
			o_dem_byte <= ~b;
		end
	endtask
endmodule

// ---- tb/testbench.sv ----
// testbench.sv: directed framer tests through fifo strobes and modem model
// assumes fskph_top, the modem model and the bound checker are compiled
`timescale 1ns/1ns
module testbench;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg tx = 1'b0, rx = 1'b0, fmt = 1'b0, stc = 1'b1, sen = 1'b1, cen = 1'b0, keep = 1'b0;
	reg wr = 1'b0, rd = 1'b0;
	reg [10:0] lim = 11'h003;
	reg [5:0] lvl = 6'h02;
	reg [1:0] af = 2'h0;
	reg [1:0] sz = 2'h1, dc = 2'h0;
	reg ct = 1'b0;
	reg [7:0] bid = 8'hFF;
	reg [7:0] pre = 8'h02, wd = 8'h00, nid = 8'h42, np;
	wire [7:0] rdat, mb, db;
	wire mv, rdy, idl, dv, lvf, dr, fu, sent, av, cp, hit, mman, dman;
	integer bad_count = 0, checks = 0, i, n;
	reg [7:0] pk[$];
	reg [7:0] ex[$];
	reg [15:0] c;
	fskph_top dut (.i_clock(clk), .i_rst(rst), .i_tx_mode(tx), .i_rx_mode(rx),
		.i_frame_format_sel(fmt), .i_payload_len_limit(lim), .i_send_start_cond(stc),
		.i_queue_level_setting(lvl), .i_sync_enable(sen), .i_sync_size(sz),
		.i_sync_pattern(32'hD391C5E7), .i_preamble_len(pre), .i_crc_enable(cen),
		.i_crc_fail_keep(keep), .i_crc_type_sel(ct), .i_dc_free_sel(dc),
		.i_addr_filter_sel(af), .i_node_identifier(nid), .i_bcast_identifier(bid),
		.i_fifo_wr(wr), .i_fifo_wdata(wd), .i_fifo_rd(rd), .o_fifo_rdata(rdat),
		.o_queue_level_flag(lvf), .o_queue_drained_flag(dr), .o_queue_full_flag(fu),
		.o_mod_byte(mb), .o_mod_valid(mv), .o_mod_manch(mman), .i_mod_ready(rdy),
		.i_mod_idle(idl), .i_dem_valid(dv), .i_dem_byte(db), .o_dem_manch(dman),
		.o_frame_sent_flag(sent), .o_payload_avail_flag(av), .o_crc_pass_flag(cp),
		.o_sync_addr_hit(hit));
	fskph_modem_model m (.i_clock(clk), .i_mod_valid(mv), .i_mod_byte(mb),
		.o_mod_ready(rdy), .o_mod_idle(idl), .o_dem_valid(dv), .o_dem_byte(db));
	// clock
	initial forever #20 clk = ~clk;
	task chk(input [7:0] g, input [7:0] e);
		begin
			checks = checks + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("[ERR] %0t got %h want %h", $time, g, e);
			end
		end
	endtask
	task put(input [7:0] b);
		begin
			@(posedge clk);
			wr <= 1'b1;
			wd <= b;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task get(input [7:0] e);
		begin
			@(posedge clk);
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			@(posedge clk);
			#1 chk(rdat, e);
		end
	endtask
	function [15:0] crcb(input [15:0] s, input [7:0] b);
		integer j;
		begin
			for (j = 7; j >= 0; j = j - 1)
				s = {s[14:0], 1'b0} ^ ((s[15] ^ b[j]) ? 16'h1021 : 16'h0000);
			crcb = s;
		end
	endfunction
	// wait for the frame, strip fill bytes, compare the rest
	task txcmp(input [7:0] fill);
		begin
			// sample settled values, a tick after each edge
			for (n = 0; n < 3000 && sent !== 1'b1; n = n + 1) begin
				@(posedge clk);
				#1;
			end
			np = 8'h00;
			while (m.got.size() > 0 && m.got[0] === fill) begin
				np = np + 8'h01;
				void'(m.got.pop_front());
			end
			for (n = 0; n < ex.size(); n = n + 1) chk(m.got[n], ex[n]);
			chk(m.got.size(), ex.size());
			chk(sent, 1'b1);
			// hand back on an edge so the caller drives there
			@(posedge clk);
		end
	endtask
	// preamble, sync, packet, optional ccitt check bytes, then drain
	task rxp(input ok, input bad);
		begin
			m.send(8'hAA);
			m.send(8'hAA);
			m.send(8'hD3);
			m.send(8'h91);
			c = 16'h1D0F;
			for (n = 0; n < pk.size(); n = n + 1) begin
				m.send(pk[n]);
				c = crcb(c, pk[n]);
			end
			c = ~c ^ {15'h0000, bad};
			if (cen) begin
				m.send(c[15:8]);
				m.send(c[7:0]);
			end
			repeat (20) @(posedge clk);
			chk(av, ok);
			if (cen && ok) chk(cp, !bad);
			if (ok || (!fmt && lim == 11'h000)) foreach (pk[k]) get(pk[k]);
			chk(dr, 1'b1);
		end
	endtask
	task conclude;
		begin
			$display("checks %0d errors %0d", checks, bad_count);
			if (bad_count == 0 && checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// hang guard
	initial begin
		repeat (40000) @(posedge clk);
		bad_count = bad_count + 1;
		conclude;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		chk(dr, 1'b1);
		// prefilled fifo, then tx entry
		put(8'h11);
		put(8'h42);
		put(8'h33);
		@(posedge clk);
		chk(lvf, 1'b1);
		ex = '{8'hD3, 8'h91, 8'h11, 8'h42, 8'h33};
		tx <= 1'b1;
		txcmp(8'hAA);
		chk(np, 8'h02);
		tx <= 1'b0;
		// paced modem, threshold start, zero preamble
		@(posedge clk);
		m.slow <= 1'b1;
		m.got.delete();
		dc <= 2'h1;
		stc <= 1'b0;
		pre <= 8'h00;
		tx <= 1'b1;
		put(8'h11);
		put(8'h22);
		repeat (60) @(posedge clk);
		for (n = 0; n < m.got.size(); n = n + 1) chk(m.got[n], 8'h00);
		put(8'h33);
		ex = '{8'hD3, 8'h91, 8'h11, 8'h22, 8'h33};
		txcmp(8'h00);
		chk(mman, 1'b1);
		tx <= 1'b0;
		// fixed length, node filter, crc good then bad
		rx <= 1'b1;
		cen <= 1'b1;
		af <= 2'h1;
		pk = '{8'h42, 8'h55, 8'h66};
		rxp(1'b1, 1'b0);
		chk(hit, 1'b1);
		rxp(1'b0, 1'b1);
		keep <= 1'b1;
		rxp(1'b1, 1'b1);
		// address table, recovery after each drop
		cen <= 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			af <= i[1] ? 2'h2 : 2'h1;
			pk = '{i[0] ? 8'h17 : 8'hFF, 8'h55, 8'h66};
			rxp(i == 2, 1'b0);
		end
		// variable length over the limit, then limit check off
		fmt <= 1'b1;
		lim <= 11'h002;
		pk = '{8'h03, 8'h42, 8'hB1, 8'hC2};
		rxp(1'b0, 1'b0);
		lim <= 11'h7FF;
		rxp(1'b1, 1'b0);
		// unlimited receive keeps flags down
		fmt <= 1'b0;
		lim <= 11'h000;
		af <= 2'h0;
		rxp(1'b0, 1'b0);
		chk(dman, 1'b1);
		chk(hit, 1'b1);
		rx <= 1'b0;
		conclude;
	end
endmodule
